// ### design/vbr_pkg.sv
/*
  Package for the backplane requester and configuration block: address constants,
  requester level defaults and the carrier structs for the grant chain.
  Assumes a single 25 MHz clock domain.
*/
`default_nettype none

package vbr_pkg;

  localparam int unsigned LA_WIDTH    = 8;
  localparam logic [7:0]  LA_RESMGR   = 8'h00;
  localparam logic [7:0]  LA_DYNAMIC  = 8'hff;
  localparam logic [7:0]  LA_DEFAULT  = 8'hff;
  localparam int unsigned NUM_LEVELS  = 4;
  localparam logic [1:0]  REQ_LEVEL_DEFAULT = 2'h3;
  localparam logic [31:0] SIG_ADDR_DEFAULT = 32'h0000_0000;

  // Active-low grant and bus request lines, one bit per level; seven interrupt request lines
  typedef struct packed {
    logic [3:0] grantInN;
  } vbr_chain_in_t;

  typedef struct packed {
    logic [3:0] grantOutN;
    logic [3:0] busReqN;
    logic [6:0] irqReqN;
  } vbr_chain_out_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_REQ   = 3'b010,
    ST_WRITE = 3'b100
  } vbr_state_t;

endpackage : vbr_pkg

`default_nettype wire

// ### design/vbr_requester.sv
/*
  Requester and configuration logic of a backplane instrument card: logical
  address capture from switches, level-selectable bus request with grant
  daisy-chain, and signal-word delivery to the commander as bus master.
  Assumes the arbiter and bus cycle engine outside; switch and grant pins are
  asynchronous and are synchronised here.
*/
// Contract
// - Address from eight switches, bit0 first
// - Address zero reserved for resource manager (code flags it on addrIllegal but still takes it as logicalAddr)
// - Address 255 selects dynamic address
// - Default switch setting is 255
// - Events sent as signal writes
// - Never drive interrupt request lines
// - Default request level three
// - Unused grant levels passed straight through
`default_nettype none

module vbr_requester
  import vbr_pkg::*;
#(
  parameter logic [1:0] REQ_LEVEL = REQ_LEVEL_DEFAULT
) (
  input  wire logic           ref_clk,
  input  wire logic           rstn,
  input  wire logic [7:0]     laSwitch,
  input  wire logic [7:0]     dynAddr,
  input  wire logic           dynAddrValid,
  input  wire logic           masterEnable,
  input  wire logic [15:0]    eventWord,
  input  wire logic           eventValid,
  output logic                eventReady,
  input  wire vbr_chain_in_t  chainIn,
  output var vbr_chain_out_t  chainOut,
  output logic [7:0]          logicalAddr,
  output logic                dynamicMode,
  output logic                addrIllegal,
  output logic                sigWriteValid,
  output logic [15:0]         sigWriteData,
  input  wire logic           sigWriteDone
);

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for switch and grant pins

  logic [7:0] swMeta_q;
  logic [7:0] swSync_q;
  logic [3:0] bgMeta_q;
  logic [3:0] bgSync_q;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      swMeta_q <= LA_DEFAULT;
      swSync_q <= LA_DEFAULT;
      bgMeta_q <= 4'hf;
      bgSync_q <= 4'hf;
    end else begin
      swMeta_q <= laSwitch;
      swSync_q <= swMeta_q;
      bgMeta_q <= chainIn.grantInN;
      bgSync_q <= bgMeta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Logical address

  logic [7:0] la_q;
  logic       dyn_q;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      la_q  <= LA_DEFAULT;
      dyn_q <= 1'b1;
    end else if (swSync_q == LA_DYNAMIC) begin
      dyn_q <= 1'b1;
      if (dynAddrValid) begin
        la_q <= dynAddr;
      end
    end else begin
      // binary switch value, bit 0 first
      dyn_q <= 1'b0;
      la_q  <= swSync_q;
    end
  end

  assign logicalAddr = la_q;
  assign dynamicMode = dyn_q;
  assign addrIllegal = (swSync_q == LA_RESMGR);

  ////////////////////////////////////////////////////////////////////////////
  // Requester state machine

  vbr_state_t state_q;
  logic [15:0] data_q;
  logic        ownGrant;

  assign ownGrant = ~bgSync_q[REQ_LEVEL];

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      data_q  <= 16'h0000;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (eventValid && masterEnable) begin
            data_q  <= eventWord;
            state_q <= ST_REQ;
          end
        end
        ST_REQ: begin
          if (ownGrant) begin
            state_q <= ST_WRITE;
          end
        end
        ST_WRITE: begin
          if (sigWriteDone) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  assign eventReady    = (state_q == ST_IDLE) && masterEnable;
  assign sigWriteValid = (state_q == ST_WRITE);
  assign sigWriteData  = data_q;

  ////////////////////////////////////////////////////////////////////////////
  // Bus request and grant chain

  logic [3:0] grantOut_q;
  logic [3:0] busReq_q;
  logic       pending;

  assign pending = (state_q != ST_IDLE);

  generate
    for (genvar i = 0; i < NUM_LEVELS; i++) begin : g_lvl
      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          grantOut_q[i] <= 1'b1;
          busReq_q[i]   <= 1'b1;
        end else if (i == int'(REQ_LEVEL)) begin
          busReq_q[i]   <= ~(state_q == ST_REQ);
          grantOut_q[i] <= pending ? 1'b1 : bgSync_q[i];
        end else begin
          busReq_q[i]   <= 1'b1;
          grantOut_q[i] <= bgSync_q[i];
        end
      end
    end
  endgenerate

  assign chainOut = '{grantOutN: grantOut_q, busReqN: busReq_q, irqReqN: 7'h7f};

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence reqSeq;
    (state_q == ST_REQ) ##1 ownGrant;
  endsequence

  noIrq_drive_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    chainOut.irqReqN == 7'h7f) else $error("interrupt line driven");

  dynamic_mode_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (swSync_q == LA_DYNAMIC) |=> dynamicMode) else $error("dynamic mode missed");

  static_addr_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (swSync_q != LA_DYNAMIC) |=> (logicalAddr == $past(swSync_q)))
    else $error("switch address not taken");

  reserved_flag_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (swSync_q == LA_RESMGR) |-> addrIllegal) else $error("reserved not flagged");

  own_request_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (state_q == ST_REQ) |=> !chainOut.busReqN[REQ_LEVEL])
    else $error("request not asserted");

  grant_write_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    reqSeq |=> sigWriteValid) else $error("grant did not start write");

  grant_fwd_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    !pending |=> (chainOut.grantOutN[REQ_LEVEL] == $past(bgSync_q[REQ_LEVEL])))
    else $error("idle grant not forwarded");

  grant_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    pending |=> chainOut.grantOutN[REQ_LEVEL]) else $error("grant leaked");

  pass_through_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    1'b1 |=> ((chainOut.grantOutN[(REQ_LEVEL + 2'd1)] ==
      $past(bgSync_q[(REQ_LEVEL + 2'd1)])) &&
      chainOut.busReqN[(REQ_LEVEL + 2'd1)]))
    else $error("unused grant not passed");

  sequence takeSeq;
    eventValid && eventReady;
  endsequence

  event_take_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    takeSeq |=> ((state_q == ST_REQ) && (sigWriteData == $past(eventWord))))
    else $error("event not taken");

  write_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (sigWriteValid && !sigWriteDone) |=> (sigWriteValid && $stable(sigWriteData)))
    else $error("write dropped early");

  idle_refuse_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    ((state_q == ST_IDLE) && !masterEnable) |=> (state_q == ST_IDLE))
    else $error("event taken while disabled");

endmodule : vbr_requester

`default_nettype wire

// ### dv/vbr_arbiter_model.sv
/*
  Arbiter and commander model for the requester bench.
  Assumes one clock and a requester on level three only.
*/
`default_nettype none
module vbr_arbiter_model (
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic reqN,
  input  wire logic writeValid,
  output logic      grant3N,
  output logic      sigWriteDone
);
  timeunit 1ns;
  timeprecision 1ns;
  ////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      grant3N      <= 1'b1;
      sigWriteDone <= 1'b0;
    end else begin
      sigWriteDone <= 1'b0;
      if (!reqN && $urandom_range(1, 0) == 1) grant3N <= 1'b0;
      // Random stall keeps the write pending a random number of cycles, possibly none
      if (writeValid && !sigWriteDone && $urandom_range(2, 0) == 0) begin
        sigWriteDone <= 1'b1;
        grant3N      <= 1'b1;
      end
    end
  end
endmodule : vbr_arbiter_model
`default_nettype wire

// ### dv/testbench.sv
/*
  Self-checking bench for the requester block.
  Assumes the arbiter model answers level three grants.
*/
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import vbr_pkg::*;
  logic ref_clk, rstn, dynAddrValid, masterEnable, eventValid, eventReady;
  logic dynamicMode, addrIllegal, sigWriteValid, sigWriteDone, grant3N, wvPrev;
  logic [7:0] laSwitch, dynAddr, logicalAddr, v;
  logic [15:0] eventWord, sigWriteData;
  logic [3:0] tbG;
  vbr_chain_in_t chainIn;
  vbr_chain_out_t chainOut;
  logic [15:0] expQ[$];
  int miscompares = 0, n_checks = 0;
  assign chainIn = {grant3N & tbG[3], tbG[2:0]};
  vbr_requester u_vbr_requester (.ref_clk(ref_clk), .rstn(rstn), .laSwitch(laSwitch),
    .dynAddr(dynAddr), .dynAddrValid(dynAddrValid), .masterEnable(masterEnable),
    .eventWord(eventWord), .eventValid(eventValid), .eventReady(eventReady),
    .chainIn(chainIn), .chainOut(chainOut), .logicalAddr(logicalAddr),
    .dynamicMode(dynamicMode), .addrIllegal(addrIllegal), .sigWriteValid(sigWriteValid),
    .sigWriteData(sigWriteData), .sigWriteDone(sigWriteDone));
  vbr_arbiter_model u_vbr_arbiter_model (.ref_clk(ref_clk), .rstn(rstn),
    .reqN(chainOut.busReqN[3]), .writeValid(sigWriteValid), .grant3N(grant3N),
    .sigWriteDone(sigWriteDone));
  ////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    if (miscompares == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic send(input logic [15:0] w);
    int i;
    @(negedge ref_clk);
    eventValid = 1'b1;
    eventWord  = w;
    expQ.push_back(w);
    for (i = 0; i < 60 && eventReady !== 1'b1; i++) @(negedge ref_clk);
    if (i == 60) begin
      miscompares++;
      report_and_stop();
    end
    @(negedge ref_clk);
    eventValid = 1'b0;
  endtask : send
  ////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // Monitor pairs each write start with the oldest queued word
  always @(negedge ref_clk) begin
    wvPrev <= sigWriteValid;
    if (sigWriteValid === 1'b1 && wvPrev !== 1'b1) begin
      if (expQ.size() == 0) chk("unexpected write", 16'h0, 16'h1);
      else chk("signal word", expQ.pop_front(), sigWriteData);
      chk("irq lines", 16'h007f, {9'h0, chainOut.irqReqN});
      chk("grant held", 16'h1, {15'h0, chainOut.grantOutN[3]});
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    {rstn, dynAddrValid, masterEnable, eventValid} = '0;
    {dynAddr, eventWord} = '0;
    laSwitch = LA_DEFAULT;
    tbG      = 4'hf;
    void'($urandom(32'haaf2f4bf));
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    rstn = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk("default address", 16'h00ff, {8'h0, logicalAddr});
    for (int k = 0; k < 6; k++) begin
      tbG = 4'($urandom);
      repeat (4) @(negedge ref_clk);
      chk("grant chain", {12'h0, tbG}, {12'h0, chainOut.grantOutN});
      chk("unused requests", 16'h0007, {13'h0, chainOut.busReqN[2:0]});
    end
    tbG = 4'hf;
    v   = 8'($urandom_range(254, 1));
    laSwitch = v;
    repeat (4) @(negedge ref_clk);
    chk("switch address", {8'h0, v}, {8'h0, logicalAddr});
    chk("fixed mode", 16'h0, {15'h0, dynamicMode});
    chk("legal address", 16'h0, {15'h0, addrIllegal});
    laSwitch = LA_RESMGR;
    repeat (4) @(negedge ref_clk);
    chk("reserved flag", 16'h1, {15'h0, addrIllegal});
    laSwitch = LA_DYNAMIC;
    dynAddr  = v ^ 8'h5a;
    repeat (4) @(negedge ref_clk);
    dynAddrValid = 1'b1;
    @(negedge ref_clk);
    dynAddrValid = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk("dynamic address", {8'h0, v ^ 8'h5a}, {8'h0, logicalAddr});
    chk("dynamic mode", 16'h1, {15'h0, dynamicMode});
    eventValid = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk("refused event", 16'h0, {15'h0, eventReady});
    chk("no request", 16'h1, {15'h0, chainOut.busReqN[3]});
    eventValid   = 1'b0;
    masterEnable = 1'b1;
    for (int k = 0; k < 8; k++) send(16'($urandom));
    for (int k = 0; k < 200 && expQ.size() > 0; k++) @(negedge ref_clk);
    chk("pending words", 16'h0, 16'(expQ.size()));
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
